// >>> src/gpio_hj_regs.svh
// Register offsets, bank numbers, reset values and field positions
// Assumes inclusion by the package file, the checker and the testbench
`ifndef GPIO_HJ_REGS_SVH
`define GPIO_HJ_REGS_SVH

// ----------------------------------------------------------------
// Banks and offsets
// ----------------------------------------------------------------
`define BANK_PORTS       4'h8
`define BANK_CONVERTER   4'h5
`define OFS_H_DIRECTION  8'h10
`define OFS_H_PIN_DATA   8'h11
`define OFS_J_DIRECTION  8'h12
`define OFS_J_PIN_DATA   8'h13
`define OFS_CONV_CONFIG  8'h15

// ----------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------
`define DIRECTION_RESET  8'hFF
`define H_UPPER_RESET    4'h0
`define CONV_RESET       8'h00
`define CONV_WRITE_MASK  8'hEF
`define PCFG_LSB         0
`define PCFG_MSB         3
`define PCFG_ALL_DIGITAL 4'hE

`endif

// >>> src/gpio_hj_pkg.sv
// Types shared by the dual port block
// Assumes the register header is on the include path
`include "gpio_hj_regs.svh"

package gpio_hj_pkg;

  // ----------------------------------------------------------------
  // Register access request from the core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // Reset cause qualifiers
  typedef struct packed {
    logic power_on;
    logic brown_out;
    logic master_clear;
    logic watchdog;
  } reset_cause_type;

  // Per port pin drive bundle
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_type;

endpackage

// >>> src/gpio_port8.sv
// One 8-bit port: direction register, output latch, sampled pins
// Assumes writes arrive as one-cycle strobes at the end of an instruction
`timescale 1ns/10ps
`default_nettype none

module gpio_port8 #(
  parameter logic [7:0] LATCH_COLD_MASK = 8'h00,  // Latch bits cleared on every reset, warm included
  parameter logic [7:0] LATCH_COLD_VAL  = 8'h00
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cold,
  // Register writes
  input  wire logic       dir_wr,
  input  wire logic       dat_wr,
  input  wire logic [7:0] wdata,
  // Pins
  input  wire logic [7:0] pin_in,
  // State
  output var  logic [7:0] direction,
  output var  logic [7:0] latch,
  output var  logic [7:0] pin_sample
);
  import gpio_hj_pkg::*;

  typedef struct packed {
    logic [7:0] direction;
    logic [7:0] latch;
    logic [7:0] sample;
  } port_state_type;

  port_state_type state;
  port_state_type next_state;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state        = state;
    next_state.sample = pin_in;             // Pin levels for the next read
    if (dir_wr) begin
      next_state.direction = wdata;
    end
    if (dat_wr) begin
      next_state.latch = wdata;             // Whole byte into all latches
    end
    if (rst) begin
      next_state.direction = `DIRECTION_RESET;
      // Masked bits clear on every reset, the rest are kept on warm reset
      next_state.latch     = (state.latch & ~LATCH_COLD_MASK) | LATCH_COLD_VAL;
      // Cold reset leaves no unknown latch bits behind
      if (cold) begin
        next_state.latch = LATCH_COLD_VAL;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign direction  = state.direction;
  assign latch      = state.latch;
  assign pin_sample = state.sample;
endmodule

`default_nettype wire

// >>> src/gpio_conv_cfg.sv
// Converter configuration register holding the analog pin select field
// Assumes writes are qualified by bank and offset upstream
`timescale 1ns/10ps
`default_nettype none

module gpio_conv_cfg (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register write
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  // Register value
  output var  logic [7:0] value
);
  import gpio_hj_pkg::*;

  typedef struct packed {
    logic [7:0] value;
  } cfg_state_type;

  cfg_state_type state;
  cfg_state_type next_state;

  // Unimplemented bit 4 stays zero
  always_comb begin
    next_state = state;
    if (wr) begin
      next_state.value = wdata & `CONV_WRITE_MASK;
    end
    if (rst) begin
      next_state.value = `CONV_RESET;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign value = state.value;
endmodule

`default_nettype wire

// >>> src/gpio_hj_top.sv
// Contract
// R1 - First port direction bit one makes pin input; zero drives it from latch (code never drives pins 7..4 while they are analog).
// R2 - First port data read returns pin levels; write loads output latches.
// R3 - First port pins 7..4 double as converter channels 12..15 in order.
// R4 - First port pins 3..0 are plain digital I/O only.
// R5 - Reset puts first port upper pins analog; software reprograms the select field.
// R6 - First port direction at 10h bank 8 resets to all ones.
// R7 - First port data: cold reset clears upper nibble; warm reset keeps lower.
// R8 - Second port direction bit one makes pin input; zero drives it.
// R9 - Second port data read returns pin levels; write loads latches.
// R10 - All eight second port pins are plain digital I/O.
// R11 - Second port direction resets to ones; latches kept on warm reset.
// R12 - Writes are read-modify-write; data read gives pins, whole byte stored.
// R13 - Latches update at cycle end; reads use pins sampled at cycle start.
// R14 - Software leaves one instruction between port write and read.
// R15 - Pins in analog mode have digital input off and read as zero.
// R16 - Port registers answer in bank 8, converter config in bank 5.
//
// Top of the two-port GPIO block on the core register port
// Assumes one register request per instruction cycle on I_REF_CLK
`timescale 1ns/10ps
`default_nettype none

module gpio_hj_top
  import gpio_hj_pkg::*;
(
  // Clock and reset
  input  wire logic                         I_REF_CLK,
  input  wire logic                         I_RESET,
  input  wire gpio_hj_pkg::reset_cause_type I_RESET_CAUSE,
  // Register port
  input  wire gpio_hj_pkg::reg_req_type     I_REG_REQ,
  output logic [7:0]                        O_REG_RDATA,
  output logic                              O_REG_RVALID,
  // First port pins
  input  wire logic [7:0]                   I_H_PIN,
  output logic [7:0]                        O_H_PIN,
  output logic [7:0]                        O_H_PIN_OE,
  output logic [3:0]                        O_H_ANALOG_SHARED_PINS,
  // Second port pins
  input  wire logic [7:0]                   I_J_PIN,
  output logic [7:0]                        O_J_PIN,
  output logic [7:0]                        O_J_PIN_OE,
  // Converter configuration
  output logic [7:0]                        O_CONVERTER_CONFIG_ONE
);
  import gpio_hj_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic       in_port_bank;
  logic       in_conv_bank;
  logic       cold;
  logic       wr_h_dir;
  logic       wr_h_dat;
  logic       wr_j_dir;
  logic       wr_j_dat;
  logic       wr_conv;
  logic [7:0] h_dir;
  logic [7:0] h_latch;
  logic [7:0] h_sample;
  logic [7:0] j_dir;
  logic [7:0] j_latch;
  logic [7:0] j_sample;
  logic [7:0] conv_cfg;
  logic [3:0] analog_upper;

  // Bank qualification of each register
  assign in_port_bank = (I_REG_REQ.bank == `BANK_PORTS);      // [R16]
  assign in_conv_bank = (I_REG_REQ.bank == `BANK_CONVERTER);  // [R16]
  assign cold         = I_RESET_CAUSE.power_on | I_RESET_CAUSE.brown_out;

  // Write strobes; latch loads at the edge that ends the cycle
  assign wr_h_dir = I_REG_REQ.wr & in_port_bank & (I_REG_REQ.addr == `OFS_H_DIRECTION);
  assign wr_h_dat = I_REG_REQ.wr & in_port_bank & (I_REG_REQ.addr == `OFS_H_PIN_DATA); // [R13]
  assign wr_j_dir = I_REG_REQ.wr & in_port_bank & (I_REG_REQ.addr == `OFS_J_DIRECTION);
  assign wr_j_dat = I_REG_REQ.wr & in_port_bank & (I_REG_REQ.addr == `OFS_J_PIN_DATA); // [R13]
  assign wr_conv  = I_REG_REQ.wr & in_conv_bank & (I_REG_REQ.addr == `OFS_CONV_CONFIG);

  // ----------------------------------------------------------------
  // Ports and converter configuration
  // ----------------------------------------------------------------
  // First port: upper nibble cleared on every reset, lower kept on warm reset
  gpio_port8 #(
    .LATCH_COLD_MASK (8'hF0),
    .LATCH_COLD_VAL  ({`H_UPPER_RESET, 4'h0})
  ) u_port_h (
    .clk        (I_REF_CLK),
    .rst        (I_RESET),
    .cold       (cold),
    .dir_wr     (wr_h_dir),
    .dat_wr     (wr_h_dat),
    .wdata      (I_REG_REQ.wdata),
    .pin_in     (I_H_PIN),
    .direction  (h_dir),
    .latch      (h_latch),
    .pin_sample (h_sample)
  ); // [R6] [R7]

  // Second port: latches kept on warm reset, defined on cold reset
  gpio_port8 #(
    .LATCH_COLD_MASK (8'h00),
    .LATCH_COLD_VAL  (8'h00)
  ) u_port_j (
    .clk        (I_REF_CLK),
    .rst        (I_RESET),
    .cold       (cold),
    .dir_wr     (wr_j_dir),
    .dat_wr     (wr_j_dat),
    .wdata      (I_REG_REQ.wdata),
    .pin_in     (I_J_PIN),
    .direction  (j_dir),
    .latch      (j_latch),
    .pin_sample (j_sample)
  ); // [R11]

  // Converter config; reset value selects analog pins
  gpio_conv_cfg u_conv (
    .clk   (I_REF_CLK),
    .rst   (I_RESET),
    .wr    (wr_conv),
    .wdata (I_REG_REQ.wdata),
    .value (conv_cfg)
  ); // [R5]

  // ----------------------------------------------------------------
  // Analog selection of the upper pins
  // ----------------------------------------------------------------
  // Field below the all-digital code keeps channels 12..15 analog
  assign analog_upper = (conv_cfg[`PCFG_MSB:`PCFG_LSB] < `PCFG_ALL_DIGITAL) ? 4'hF : 4'h0; // [R5]

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
    logic [7:0] h_out;
    logic [7:0] h_oe;
    logic [3:0] h_analog;
    logic [7:0] j_out;
    logic [7:0] j_oe;
    logic [7:0] conv;
  } top_state_type;

  top_state_type state;
  top_state_type next_state;
  logic [7:0]    h_read;

  always_comb begin
    next_state        = state;
    // Digital input path gated off for analog pins
    h_read            = h_sample & ~{analog_upper, 4'h0}; // [R15] [R2]
    next_state.rvalid = I_REG_REQ.rd;
    next_state.rdata  = 8'h00;
    // Read returns pins sampled at cycle start; a write-side read is the same
    if (I_REG_REQ.rd) begin
      if (in_port_bank) begin
        unique case (I_REG_REQ.addr)
          `OFS_H_DIRECTION: next_state.rdata = h_dir;
          `OFS_H_PIN_DATA:  next_state.rdata = h_read;      // [R2] [R12] [R13]
          `OFS_J_DIRECTION: next_state.rdata = j_dir;
          `OFS_J_PIN_DATA:  next_state.rdata = j_sample;    // [R9] [R12] [R13]
          default:          next_state.rdata = 8'h00;
        endcase
      end else if (in_conv_bank && I_REG_REQ.addr == `OFS_CONV_CONFIG) begin
        next_state.rdata = conv_cfg;
      end
    end
    // Drivers: direction one disables the driver
    next_state.h_out    = h_latch;
    next_state.h_oe     = ~h_dir & ~{analog_upper, 4'h0}; // [R1] [R4] [R3]
    next_state.h_analog = analog_upper;                    // [R3]
    next_state.j_out    = j_latch;
    next_state.j_oe     = ~j_dir;                          // [R8] [R10]
    next_state.conv     = conv_cfg;
    if (I_RESET) begin
      next_state.rvalid   = 1'b0;
      next_state.h_oe     = 8'h00;
      next_state.j_oe     = 8'h00;
      next_state.h_analog = 4'hF;
    end
  end

  // Output register
  always_ff @(posedge I_REF_CLK) begin
    state <= next_state;
  end

  assign O_REG_RDATA            = state.rdata;
  assign O_REG_RVALID           = state.rvalid;
  assign O_H_PIN                = state.h_out;
  assign O_H_PIN_OE             = state.h_oe;
  assign O_H_ANALOG_SHARED_PINS = state.h_analog;
  assign O_J_PIN                = state.j_out;
  assign O_J_PIN_OE             = state.j_oe;
  assign O_CONVERTER_CONFIG_ONE = state.conv;
endmodule

`default_nettype wire

// >>> test/board_model.sv
// Board circuitry on one 8-bit port
// Assumes a weak pull-up on every pin
`timescale 1ns/10ps
`default_nettype none

module board_model (
  // Device side
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  // Board drivers
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_ext_en,
  // Resolved level
  output wire logic [7:0] o_pin
);
  // Device first, then board, else pull-up
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext) | (~i_oe & ~i_ext_en);
endmodule

`default_nettype wire

// >>> test/gpio_hj_props.sv
// Checker on the top ports of the two-port block
// Assumes the register header on the include path
`timescale 1ns/10ps
`default_nettype none
`include "gpio_hj_regs.svh"

module gpio_hj_props
  import gpio_hj_pkg::*;
(
  // Clock, reset and requests
  input wire logic                         I_REF_CLK,
  input wire logic                         I_RESET,
  input wire gpio_hj_pkg::reset_cause_type I_RESET_CAUSE,
  input wire gpio_hj_pkg::reg_req_type     I_REG_REQ,
  input wire logic [7:0]                   O_REG_RDATA,
  input wire logic                         O_REG_RVALID,
  // Pins and config
  input wire logic [7:0]                   I_H_PIN,
  input wire logic [7:0]                   O_H_PIN,
  input wire logic [7:0]                   O_H_PIN_OE,
  input wire logic [3:0]                   O_H_ANALOG_SHARED_PINS,
  input wire logic [7:0]                   I_J_PIN,
  input wire logic [7:0]                   O_J_PIN,
  input wire logic [7:0]                   O_J_PIN_OE,
  input wire logic [7:0]                   O_CONVERTER_CONFIG_ONE
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  logic b8;
  logic wj;
  logic dj;
  logic rj;
  logic rc;
  logic rx;
  // Request decodes
  assign b8 = I_REG_REQ.bank == `BANK_PORTS;
  assign wj = I_REG_REQ.wr && b8 && I_REG_REQ.addr == `OFS_J_PIN_DATA;
  assign dj = I_REG_REQ.wr && b8 && I_REG_REQ.addr == `OFS_J_DIRECTION;
  assign rj = I_REG_REQ.rd && b8 && I_REG_REQ.addr == `OFS_J_PIN_DATA;
  assign rc = I_REG_REQ.rd && I_REG_REQ.bank == `BANK_CONVERTER
              && I_REG_REQ.addr == `OFS_CONV_CONFIG;
  assign rx = I_REG_REQ.rd && !b8 && I_REG_REQ.bank != `BANK_CONVERTER;

  a_rvalid_after_rd: assert property (I_REG_REQ.rd |=> O_REG_RVALID)
    else $error("read answer missing");
  a_rvalid_no_rd: assert property (!I_REG_REQ.rd |=> !O_REG_RVALID)
    else $error("read answer unasked");
  a_rdata_idle: assert property (!O_REG_RVALID |-> O_REG_RDATA == 8'h00)
    else $error("read data not idle");
  a_reset_values: assert property ($fell(I_RESET) |-> O_H_PIN_OE == 8'h00
    && O_J_PIN_OE == 8'h00 && O_H_ANALOG_SHARED_PINS == 4'hF)
    else $error("reset values wrong");
  a_j_latch_load: assert property (wj |-> ##2 O_J_PIN == $past(I_REG_REQ.wdata, 2))
    else $error("second port latch wrong");
  a_j_dir_load: assert property (dj |-> ##2 O_J_PIN_OE == ~$past(I_REG_REQ.wdata, 2))
    else $error("second port enable wrong");
  a_analog_undriven: assert property ((O_H_ANALOG_SHARED_PINS & O_H_PIN_OE[7:4]) == 4'h0)
    else $error("analog pin driven");
  a_j_pin_read: assert property (rj |=> O_REG_RDATA == $past(I_J_PIN, 2))
    else $error("pin read not start sample");
  a_cfg_read: assert property (rc |=> O_REG_RDATA == O_CONVERTER_CONFIG_ONE)
    else $error("config read wrong");
  a_unmapped_zero: assert property (rx |=> O_REG_RDATA == 8'h00)
    else $error("unmapped read not zero");

  c_j_write: cover property (wj);
  c_j_read: cover property (rj);
  c_unmapped: cover property (rx);
endmodule

bind gpio_hj_top gpio_hj_props u_props (.I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET),
  .I_RESET_CAUSE(I_RESET_CAUSE), .I_REG_REQ(I_REG_REQ), .O_REG_RDATA(O_REG_RDATA),
  .O_REG_RVALID(O_REG_RVALID), .I_H_PIN(I_H_PIN), .O_H_PIN(O_H_PIN),
  .O_H_PIN_OE(O_H_PIN_OE), .O_H_ANALOG_SHARED_PINS(O_H_ANALOG_SHARED_PINS),
  .I_J_PIN(I_J_PIN), .O_J_PIN(O_J_PIN), .O_J_PIN_OE(O_J_PIN_OE),
  .O_CONVERTER_CONFIG_ONE(O_CONVERTER_CONFIG_ONE));

`default_nettype wire

// >>> test/tb.sv
// Testbench for the two-port block
// Assumes design, checker and board model compiled first
`timescale 1ns/10ps
`default_nettype none
`include "gpio_hj_regs.svh"

module tb;
  import gpio_hj_pkg::*;
  logic            clk = 1'h0;
  logic            rst = 1'h1;
  reset_cause_type cause = 4'h8;
  reg_req_type     req = '0;
  logic [7:0]      rdata;
  logic            rvalid;
  wire logic [7:0] h_pin;
  wire logic [7:0] j_pin;
  logic [7:0]      h_out;
  logic [7:0]      h_oe;
  logic [3:0]      h_ana;
  logic [7:0]      j_out;
  logic [7:0]      j_oe;
  logic [7:0]      cfg;
  logic [7:0]      h_ext = 8'hFF;
  logic [7:0]      h_en = 8'hFF;
  logic [7:0]      j_ext = 8'h00;
  logic [7:0]      j_en = 8'h00;
  int              n_errors = 0;
  int              compares = 0;

  // Clock
  always #10 clk = ~clk;

  gpio_hj_top u_dut (.I_REF_CLK(clk), .I_RESET(rst), .I_RESET_CAUSE(cause),
    .I_REG_REQ(req), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .I_H_PIN(h_pin),
    .O_H_PIN(h_out), .O_H_PIN_OE(h_oe), .O_H_ANALOG_SHARED_PINS(h_ana),
    .I_J_PIN(j_pin), .O_J_PIN(j_out), .O_J_PIN_OE(j_oe), .O_CONVERTER_CONFIG_ONE(cfg));
  board_model u_bh (.i_out(h_out), .i_oe(h_oe), .i_ext(h_ext), .i_ext_en(h_en), .o_pin(h_pin));
  board_model u_bj (.i_out(j_out), .i_oe(j_oe), .i_ext(j_ext), .i_ext_en(j_en), .o_pin(j_pin));

  task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", w, exp, seen);
    end
  endtask

  // Write, then one idle cycle so the pin settles
  task automatic wr(input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{1'h1, 1'h0, b, a, d};
    @(negedge clk);
    req <= '0;
    @(negedge clk);
  endtask

  task automatic rd(input string w, input logic [3:0] b, input logic [7:0] a,
                    input logic [7:0] e);
    @(negedge clk);
    req <= '{1'h0, 1'h1, b, a, 8'h00};
    @(negedge clk);
    req <= '0;
    check("rvalid", {7'h00, rvalid}, 8'h01);
    check(w, rdata, e);
  endtask

  task automatic do_reset(input logic cold);
    @(negedge clk);
    rst <= 1'h1;
    cause <= '{cold, 1'h0, 1'h0, ~cold};
    repeat (8) @(negedge clk);
    rst <= 1'h0;
  endtask

  task automatic t_reset;
    rd("h_dir", `BANK_PORTS, `OFS_H_DIRECTION, 8'hFF);
    rd("j_dir", `BANK_PORTS, `OFS_J_DIRECTION, 8'hFF);
    rd("cfg", `BANK_CONVERTER, `OFS_CONV_CONFIG, 8'h00);
    rd("h_data", `BANK_PORTS, `OFS_H_PIN_DATA, 8'h0F);
    check("h_ana", {4'h0, h_ana}, 8'h0F);
    check("h_hi", {4'h0, h_out[7:4]}, 8'h00);
  endtask

  task automatic t_h;
    wr(`BANK_CONVERTER, `OFS_CONV_CONFIG, 8'hFF);
    rd("cfg", `BANK_CONVERTER, `OFS_CONV_CONFIG, 8'hEF);
    check("cfg_out", cfg, 8'hEF);
    check("h_ana", {4'h0, h_ana}, 8'h00);
    wr(`BANK_PORTS, `OFS_H_PIN_DATA, 8'hA5);
    wr(`BANK_PORTS, `OFS_H_DIRECTION, 8'h0F);
    h_en = 8'h0F;
    h_ext = 8'h03;
    check("h_oe", h_oe, 8'hF0);
    check("h_out", h_out, 8'hA5);
    rd("h_data", `BANK_PORTS, `OFS_H_PIN_DATA, 8'hA3);
    wr(`BANK_CONVERTER, `OFS_CONV_CONFIG, 8'h00);
    check("h_ana", {4'h0, h_ana}, 8'h0F);
    check("h_oe", h_oe, 8'h00);
    rd("h_data", `BANK_PORTS, `OFS_H_PIN_DATA, 8'h03);
  endtask

  task automatic t_j;
    wr(`BANK_PORTS, `OFS_J_PIN_DATA, 8'h5C);
    wr(`BANK_PORTS, `OFS_J_DIRECTION, 8'hCF);
    j_en = 8'hC3;
    j_ext = 8'h41;
    check("j_oe", j_oe, 8'h30);
    check("j_out", j_out, 8'h5C);
    rd("j_data", `BANK_PORTS, `OFS_J_PIN_DATA, 8'h5D);
    wr(`BANK_PORTS, `OFS_J_PIN_DATA, 8'h5D | 8'h80);
    check("j_rmw", j_out, 8'hDD);
    wr(4'h3, `OFS_J_DIRECTION, 8'h00);
    check("j_oe", j_oe, 8'h30);
    rd("unmapped", 4'h3, `OFS_J_DIRECTION, 8'h00);
  endtask

  task automatic t_warm;
    do_reset(1'h0);
    @(negedge clk);
    check("j_out", j_out, 8'hDD);
    check("h_lo", {4'h0, h_out[3:0]}, 8'h05);
    check("h_hi", {4'h0, h_out[7:4]}, 8'h00);
    check("cfg_out", cfg, 8'h00);
    check("h_oe", h_oe, 8'h00);
    check("j_oe", j_oe, 8'h00);
    check("h_ana", {4'h0, h_ana}, 8'h0F);
  endtask

  task automatic summarize;
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    do_reset(1'h1);
    t_reset;
    t_h;
    t_j;
    t_warm;
    summarize;
  end

  // Hang guard
  initial begin
    #200000;
    n_errors++;
    summarize;
  end
endmodule

`default_nettype wire
